// ===== rtl/pmrc_pkg.sv
// package of constants, register map and types for the power mode and reset controller
package pmrc_pkg;

	// ============================================================
	// register map (byte offsets)
	localparam logic [7:0] PMRC_MODE_OFS = 8'h00;
	localparam logic [7:0] PMRC_ACT_TMPL_OFS = 8'h04;
	localparam logic [7:0] PMRC_ALT_TMPL_OFS = 8'h08;
	localparam logic [7:0] PMRC_WAKE_EN_OFS = 8'h0c;
	localparam logic [7:0] PMRC_BOOST_OFS = 8'h10;
	localparam logic [7:0] PMRC_WDOG_OFS = 8'h14;
	localparam logic [7:0] PMRC_RST_STAT_OFS = 8'h18;
	localparam logic [7:0] PMRC_SRES_OFS = 8'h1c;
	localparam logic [7:0] PMRC_CTW_OFS = 8'h20;
	localparam logic [7:0] PMRC_SVM_OFS = 8'h24;
	localparam logic [7:0] PMRC_STATUS_OFS = 8'h28;

	// ============================================================
	// widths and field positions
	localparam int PMRC_NSUB = 8;
	localparam int PMRC_NWAKE = 8;
	localparam int PMRC_CPU_BIT = 0;
	localparam int PMRC_WAKE_CTW = 6;
	localparam int PMRC_WAKE_SVM = 7;
	localparam int PMRC_BST_EN_BIT = 0;
	localparam int PMRC_BST_STBY_BIT = 1;
	localparam int PMRC_BST_ATM_BIT = 2;
	localparam int PMRC_BST_FLO = 4;
	localparam int PMRC_BST_FHI = 5;
	localparam int PMRC_WD_EN_BIT = 0;
	localparam int PMRC_WD_KICK_BIT = 1;
	localparam int PMRC_SRES_GO_BIT = 0;
	localparam int PMRC_SRES_DIS_BIT = 1;
	localparam int PMRC_SVM_RST_BIT = 0;

	// reset status bits
	localparam int PMRC_RS_EXTERNAL_RESET_PIN = 0;
	localparam int PMRC_RS_WDOG = 1;
	localparam int PMRC_RS_PRECISE_LOW_VOLTAGE_RESET = 2;
	localparam int PMRC_RS_SRES = 3;
	localparam int PMRC_RS_SVM_RST = 4;
	localparam int PMRC_RS_SVM_IRQ = 5;

	// ============================================================
	// reset values
	localparam logic [PMRC_NSUB-1:0] PMRC_ACT_TMPL_RST = 8'hff;
	localparam logic [PMRC_NSUB-1:0] PMRC_ALT_TMPL_RST = 8'hfe;
	localparam logic [31:0] PMRC_WD_PERIOD_RST = 32'h000f_ffff;
	localparam logic [31:0] PMRC_CTW_PERIOD_RST = 32'h0003_ffff;
	localparam logic [1:0] PMRC_AXI_OKAY = 2'h0;
	localparam logic [1:0] PMRC_AXI_SLVERR = 2'h2;

	// ============================================================
	// timing
	localparam int PMRC_CLK_MHZ = 250;
	localparam int PMRC_SLEEP_RESUME_US = 15;
	localparam int PMRC_HIB_RESUME_US = 100;
	// least time rounds up; longest time rounds down
	localparam int PMRC_SLEEP_CYC = PMRC_SLEEP_RESUME_US * PMRC_CLK_MHZ;
	localparam int PMRC_HIB_CYC = PMRC_HIB_RESUME_US * PMRC_CLK_MHZ - 1;
	localparam int PMRC_TMR_W = 16;

	// ============================================================
	// mode commands and boost frequency select
	localparam logic [1:0] PMRC_CMD_ACTIVE = 2'h0;
	localparam logic [1:0] PMRC_CMD_ALT = 2'h1;
	localparam logic [1:0] PMRC_CMD_SLEEP = 2'h2;
	localparam logic [1:0] PMRC_CMD_HIB = 2'h3;
	localparam logic [1:0] PMRC_F100K = 2'h0;
	localparam logic [1:0] PMRC_F400K = 2'h1;
	localparam logic [1:0] PMRC_F2M = 2'h2;
	localparam logic [1:0] PMRC_F32K = 2'h3;

	// gray coded along active -> entry -> sleep -> resume
	typedef enum logic [2:0] {
		PMRC_ST_ACTIVE = 3'h0,
		PMRC_ST_ALT = 3'h4,
		PMRC_ST_ENTER = 3'h1,
		PMRC_ST_SLEEP = 3'h3,
		PMRC_ST_HIB = 3'h7,
		PMRC_ST_RESUME = 3'h2
	} pmrc_state_t;

endpackage : pmrc_pkg

// ===== rtl/pmrc_cnt.sv
// down counter with load that pulses when it reaches zero
`timescale 1ns/1ps
module pmrc_cnt
	import pmrc_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// control
	input wire logic run,
	input wire logic load,
	input wire logic [31:0] period,
	// result
	output logic expired
);

	logic [31:0] count_reg;

	always_ff @(posedge sys_clk) begin
		if (reset || load || !run) begin
			count_reg <= period;
		end else if (count_reg == 32'h0) begin
			count_reg <= period;
		end else begin
			count_reg <= count_reg - 32'h1;
		end
	end

	assign expired = run && !load && (count_reg == 32'h0);

endmodule : pmrc_cnt

// ===== rtl/pmrc_ctrl.sv
// power mode, boost mode and reset controller with an axi4-lite register slave
//
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module pmrc_ctrl
	import pmrc_pkg::*;
#(
	parameter int SLEEP_CYCLES = PMRC_SLEEP_CYC,
	parameter int HIB_CYCLES = PMRC_HIB_CYC
) (
	// clock and power on reset
	input wire logic sys_clk,
	input wire logic reset,
	// axi4-lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// reset and wakeup sources
	input wire logic external_reset_pin_n,
	input wire logic precise_low_voltage_reset,
	input wire logic supply_out_of_range,
	input wire logic supply_near_limit,
	input wire logic [PMRC_NWAKE-1:0] wake_irq,
	input wire logic pin_irq,
	// boost converter
	input wire logic boost_below_target,
	input wire logic xtal_32k,
	output logic boost_enable,
	output logic boost_standby,
	output logic [1:0] boost_freq_sel,
	output logic boost_pulse,
	// subsystem and mode outputs
	output logic [PMRC_NSUB-1:0] subsys_enable,
	output logic [PMRC_NSUB-1:0] subsys_clk_en,
	output logic [1:0] power_mode,
	output logic io_hold,
	output logic supply_irq,
	output logic timewheel_irq,
	output logic device_reset
);

	// ============================================================
	// state
	pmrc_state_t state_reg, state_next;
	logic [1:0] lp_target_reg;
	logic [PMRC_TMR_W-1:0] timer_reg;
	logic [PMRC_NSUB-1:0] act_tmpl_reg, alt_tmpl_reg;
	logic [PMRC_NWAKE-1:0] wake_en_reg;
	logic [31:0] boost_reg, wd_period_reg, ctw_period_reg;
	logic [5:0] rst_stat_reg;
	logic wd_en_reg, sres_dis_reg, svm_rst_reg, cpu_off_reg, ctw_irq_reg, svm_irq_reg;
	logic xtal_d_reg, dev_rst_reg, sres_req_reg, wd_kick;
	logic wd_expired, ctw_tick, wake_any, wake_hib, go_active;
	logic [1:0] mode_cmd;
	logic mode_cmd_vld;

	// ============================================================
	// axi4-lite slave
	logic aw_hold_reg, w_hold_reg, ar_busy_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic wr_go;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic known(input logic [7:0] a);
		known = (a[1:0] == 2'h0) && (a <= PMRC_STATUS_OFS);
	endfunction : known

	assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_hold_reg && !s_axi_bvalid;
	assign s_axi_arready = !ar_busy_reg;
	assign wr_go = aw_hold_reg && w_hold_reg;
	assign s_axi_bvalid = wr_go;
	assign s_axi_rvalid = ar_busy_reg;

	always_ff @(posedge sys_clk) begin
		if (dev_rst_reg || reset) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			aw_addr_reg <= 8'h0;
			w_data_reg <= 32'h0;
			w_strb_reg <= 4'h0;
		end else if (wr_go && s_axi_bready) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
		end
	end

	logic wr_fire;
	assign wr_fire = wr_go && s_axi_bready;
	assign s_axi_bresp = known(aw_addr_reg) ? PMRC_AXI_OKAY : PMRC_AXI_SLVERR;

	always_ff @(posedge sys_clk) begin
		if (dev_rst_reg || reset) begin
			ar_busy_reg <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= PMRC_AXI_OKAY;
		end else if (ar_busy_reg) begin
			if (s_axi_rready) begin
				ar_busy_reg <= 1'b0;
			end
		end else if (s_axi_arvalid) begin
			ar_busy_reg <= 1'b1;
			s_axi_rresp <= known(s_axi_araddr) ? PMRC_AXI_OKAY : PMRC_AXI_SLVERR;
			case (s_axi_araddr)
				PMRC_MODE_OFS: s_axi_rdata <= {30'h0, power_mode};
				PMRC_ACT_TMPL_OFS: s_axi_rdata <= {24'h0, act_tmpl_reg};
				PMRC_ALT_TMPL_OFS: s_axi_rdata <= {24'h0, alt_tmpl_reg};
				PMRC_WAKE_EN_OFS: s_axi_rdata <= {24'h0, wake_en_reg};
				PMRC_BOOST_OFS: s_axi_rdata <= boost_reg;
				PMRC_WDOG_OFS: s_axi_rdata <= {31'h0, wd_en_reg};
				PMRC_RST_STAT_OFS: s_axi_rdata <= {26'h0, rst_stat_reg};
				PMRC_SRES_OFS: s_axi_rdata <= {30'h0, sres_dis_reg, 1'b0};
				PMRC_CTW_OFS: s_axi_rdata <= ctw_period_reg;
				PMRC_SVM_OFS: s_axi_rdata <= {31'h0, svm_rst_reg};
				PMRC_STATUS_OFS: s_axi_rdata <= {28'h0, cpu_off_reg, state_reg};
				default: s_axi_rdata <= 32'h0;
			endcase
		end
	end

	// ============================================================
	// configuration registers, loaded with their reset values by device reset
	assign mode_cmd_vld = wr_fire && (aw_addr_reg == PMRC_MODE_OFS) && w_strb_reg[0];
	assign mode_cmd = w_data_reg[1:0];
	assign wd_kick = wr_fire && (aw_addr_reg == PMRC_WDOG_OFS) && w_strb_reg[0]
		&& w_data_reg[PMRC_WD_KICK_BIT];

	always_ff @(posedge sys_clk) begin
		if (dev_rst_reg || reset) begin
			act_tmpl_reg <= PMRC_ACT_TMPL_RST;
			alt_tmpl_reg <= PMRC_ALT_TMPL_RST;
			wake_en_reg <= '0;
			boost_reg <= 32'h0;
			ctw_period_reg <= PMRC_CTW_PERIOD_RST;
			wd_period_reg <= PMRC_WD_PERIOD_RST;
			sres_dis_reg <= 1'b0;
			svm_rst_reg <= 1'b0;
		end else if (wr_fire) begin
			case (aw_addr_reg)
				PMRC_ACT_TMPL_OFS: act_tmpl_reg <= PMRC_NSUB'(merge({24'h0, act_tmpl_reg},
					w_data_reg, w_strb_reg));
				PMRC_ALT_TMPL_OFS: alt_tmpl_reg <= PMRC_NSUB'(merge({24'h0, alt_tmpl_reg},
					w_data_reg, w_strb_reg));
				PMRC_WAKE_EN_OFS: wake_en_reg <= PMRC_NWAKE'(merge({24'h0, wake_en_reg},
					w_data_reg, w_strb_reg));
				PMRC_BOOST_OFS: boost_reg <= merge(boost_reg, w_data_reg, w_strb_reg);
				PMRC_CTW_OFS: ctw_period_reg <= merge(ctw_period_reg, w_data_reg, w_strb_reg);
				PMRC_SRES_OFS: sres_dis_reg <= sres_dis_reg | w_data_reg[PMRC_SRES_DIS_BIT];
				PMRC_SVM_OFS: svm_rst_reg <= w_data_reg[PMRC_SVM_RST_BIT];
				default: ;
			endcase
		end
	end

	// watchdog enable clears only on power on reset
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wd_en_reg <= 1'b0;
		end else if (wr_fire && aw_addr_reg == PMRC_WDOG_OFS && w_data_reg[PMRC_WD_EN_BIT]) begin
			wd_en_reg <= 1'b1;
		end
	end

	// ============================================================
	// watchdog and timewheel
	pmrc_cnt u_wdog (
		.sys_clk(sys_clk),
		.reset(reset || dev_rst_reg),
		.run(wd_en_reg),
		.load(wd_kick),
		.period(wd_period_reg),
		.expired(wd_expired)
	);

	// reload one cycle after a period write so the counter sees the new period
	logic ctw_load_reg;
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ctw_load_reg <= 1'b0;
		end else begin
			ctw_load_reg <= wr_fire && aw_addr_reg == PMRC_CTW_OFS;
		end
	end

	pmrc_cnt u_ctw (
		.sys_clk(sys_clk),
		.reset(reset || dev_rst_reg),
		.run(state_reg != PMRC_ST_HIB),
		.load(ctw_load_reg),
		.period(ctw_period_reg),
		.expired(ctw_tick)
	);

	// ============================================================
	// reset gathering
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sres_req_reg <= 1'b0;
		end else begin
			sres_req_reg <= wr_fire && aw_addr_reg == PMRC_SRES_OFS && !sres_dis_reg
				&& w_data_reg[PMRC_SRES_GO_BIT];
		end
	end

	logic svm_reset_ev;
	assign svm_reset_ev = supply_out_of_range || (supply_near_limit && svm_rst_reg);

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			dev_rst_reg <= 1'b0;
		end else begin
			dev_rst_reg <= !external_reset_pin_n || wd_expired || precise_low_voltage_reset
				|| sres_req_reg || svm_reset_ev;
		end
	end
	assign device_reset = dev_rst_reg;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rst_stat_reg <= '0;
		end else if (!external_reset_pin_n || wd_expired || precise_low_voltage_reset
				|| sres_req_reg || svm_reset_ev || (supply_near_limit && !svm_rst_reg)) begin
			rst_stat_reg <= '0;
			rst_stat_reg[PMRC_RS_EXTERNAL_RESET_PIN] <= !external_reset_pin_n;
			rst_stat_reg[PMRC_RS_WDOG] <= wd_expired;
			rst_stat_reg[PMRC_RS_PRECISE_LOW_VOLTAGE_RESET] <= precise_low_voltage_reset;
			rst_stat_reg[PMRC_RS_SRES] <= sres_req_reg;
			rst_stat_reg[PMRC_RS_SVM_RST] <= svm_reset_ev;
			rst_stat_reg[PMRC_RS_SVM_IRQ] <= supply_near_limit && !svm_rst_reg;
		end
	end

	// ============================================================
	// supervisor and timewheel interrupt flags, set wins over read clear
	logic stat_rd;
	assign stat_rd = s_axi_arvalid && !ar_busy_reg && s_axi_araddr == PMRC_RST_STAT_OFS;

	always_ff @(posedge sys_clk) begin
		if (reset || dev_rst_reg) begin
			svm_irq_reg <= 1'b0;
			ctw_irq_reg <= 1'b0;
		end else begin
			svm_irq_reg <= (supply_near_limit && !svm_rst_reg) || (svm_irq_reg && !stat_rd);
			ctw_irq_reg <= ctw_tick || (ctw_irq_reg && !(stat_rd || mode_cmd_vld));
		end
	end
	assign supply_irq = svm_irq_reg;
	assign timewheel_irq = ctw_irq_reg;

	// ============================================================
	// wakeup and power mode sequencing
	logic [PMRC_NWAKE-1:0] wake_src;
	always_comb begin
		wake_src = wake_irq;
		wake_src[PMRC_WAKE_CTW] = wake_irq[PMRC_WAKE_CTW] || ctw_tick;
		wake_src[PMRC_WAKE_SVM] = wake_irq[PMRC_WAKE_SVM] || supply_near_limit;
	end
	assign wake_any = |(wake_src & wake_en_reg) || pin_irq || !external_reset_pin_n
		|| wd_expired || precise_low_voltage_reset;
	assign wake_hib = pin_irq || !external_reset_pin_n;
	assign go_active = (state_reg == PMRC_ST_RESUME) && (timer_reg == '0);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			PMRC_ST_ACTIVE, PMRC_ST_ALT: begin
				if (mode_cmd_vld) begin
					case (mode_cmd)
						PMRC_CMD_ALT: state_next = PMRC_ST_ALT;
						PMRC_CMD_ACTIVE: state_next = PMRC_ST_ACTIVE;
						default: state_next = PMRC_ST_ENTER;
					endcase
				end else if (state_reg == PMRC_ST_ALT && wake_any) begin
					state_next = PMRC_ST_ACTIVE;
				end
			end
			PMRC_ST_ENTER: begin
				if (wake_any) begin
					state_next = PMRC_ST_ACTIVE;
				end else if (lp_target_reg == PMRC_CMD_HIB) begin
					state_next = PMRC_ST_HIB;
				end else begin
					state_next = PMRC_ST_SLEEP;
				end
			end
			PMRC_ST_SLEEP: if (wake_any) state_next = PMRC_ST_RESUME;
			PMRC_ST_HIB: if (wake_hib) state_next = PMRC_ST_RESUME;
			PMRC_ST_RESUME: if (go_active) state_next = PMRC_ST_ACTIVE;
			default: state_next = PMRC_ST_ACTIVE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset || dev_rst_reg) begin
			state_reg <= PMRC_ST_ACTIVE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset || dev_rst_reg) begin
			lp_target_reg <= PMRC_CMD_ACTIVE;
			timer_reg <= '0;
		end else begin
			if (mode_cmd_vld) begin
				lp_target_reg <= mode_cmd;
			end
			if (state_reg == PMRC_ST_SLEEP && state_next == PMRC_ST_RESUME) begin
				timer_reg <= PMRC_TMR_W'(SLEEP_CYCLES - 1);
			end else if (state_reg == PMRC_ST_HIB && state_next == PMRC_ST_RESUME) begin
				timer_reg <= PMRC_TMR_W'(HIB_CYCLES - 1);
			end else if (timer_reg != '0) begin
				timer_reg <= timer_reg - 1'b1;
			end
		end
	end

	// cpu self disable, written as bit 3 of the status register
	always_ff @(posedge sys_clk) begin
		if (reset || dev_rst_reg) begin
			cpu_off_reg <= 1'b0;
		end else if (wake_any || state_next == PMRC_ST_ACTIVE && state_reg != PMRC_ST_ACTIVE) begin
			cpu_off_reg <= 1'b0;
		end else if (wr_fire && aw_addr_reg == PMRC_STATUS_OFS) begin
			cpu_off_reg <= w_data_reg[3];
		end
	end

	// a wakeup keeps the processor on in active mode until firmware rewrites the active template, unless the cpu self disable bit is set
	logic cpu_wake_reg;
	always_ff @(posedge sys_clk) begin
		if (reset || dev_rst_reg) begin
			cpu_wake_reg <= 1'b0;
		end else if (wake_any) begin
			cpu_wake_reg <= 1'b1;
		end else if (wr_fire && aw_addr_reg == PMRC_ACT_TMPL_OFS) begin
			cpu_wake_reg <= 1'b0;
		end
	end

	// ============================================================
	// subsystem enables and clock gating
	logic [PMRC_NSUB-1:0] tmpl;
	always_comb begin
		case (state_reg)
			PMRC_ST_ACTIVE: tmpl = act_tmpl_reg;
			PMRC_ST_ALT: tmpl = alt_tmpl_reg;
			default: tmpl = '0;
		endcase
		if (state_reg == PMRC_ST_ACTIVE) begin
			tmpl[PMRC_CPU_BIT] = (act_tmpl_reg[PMRC_CPU_BIT] || cpu_wake_reg)
				&& !cpu_off_reg;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			subsys_enable <= PMRC_ACT_TMPL_RST;
			power_mode <= PMRC_CMD_ACTIVE;
			io_hold <= 1'b0;
		end else begin
			subsys_enable <= tmpl;
			power_mode <= (state_reg == PMRC_ST_ALT) ? PMRC_CMD_ALT
				: (state_reg == PMRC_ST_SLEEP) ? PMRC_CMD_SLEEP
				: (state_reg == PMRC_ST_HIB) ? PMRC_CMD_HIB : PMRC_CMD_ACTIVE;
			io_hold <= state_reg == PMRC_ST_HIB;
		end
	end
	assign subsys_clk_en = subsys_enable;

	// ============================================================
	// boost converter control
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			boost_enable <= 1'b0;
			boost_standby <= 1'b0;
			boost_freq_sel <= PMRC_F100K;
			xtal_d_reg <= 1'b0;
			boost_pulse <= 1'b0;
		end else begin
			boost_enable <= boost_reg[PMRC_BST_EN_BIT];
			boost_standby <= boost_reg[PMRC_BST_STBY_BIT] && state_reg != PMRC_ST_HIB;
			boost_freq_sel <= boost_reg[PMRC_BST_FHI:PMRC_BST_FLO];
			xtal_d_reg <= xtal_32k;
			boost_pulse <= boost_reg[PMRC_BST_EN_BIT] && boost_reg[PMRC_BST_ATM_BIT]
				&& boost_below_target && (xtal_32k != xtal_d_reg);
		end
	end

endmodule : pmrc_ctrl

// ===== testbench/pmrc_checker.sv
// port assertions for the power mode and reset controller
`timescale 1ns/1ps
module pmrc_checker
	import pmrc_pkg::*;
#(
	parameter int HIB_CYCLES = PMRC_HIB_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// pins
	input wire logic external_reset_pin_n,
	input wire logic pin_irq,
	// outputs
	input wire logic boost_enable,
	input wire logic boost_standby,
	input wire logic boost_pulse,
	input wire logic [PMRC_NSUB-1:0] subsys_enable,
	input wire logic [PMRC_NSUB-1:0] subsys_clk_en,
	input wire logic [1:0] power_mode,
	input wire logic io_hold,
	input wire logic device_reset
);
	// ============================================================
	// hibernate resume timer
	logic pend_reg;
	logic [15:0] wait_reg;
	always_ff @(posedge sys_clk) begin
		if (reset || power_mode == PMRC_CMD_ACTIVE) begin
			pend_reg <= 1'b0;
			wait_reg <= 16'h0000;
		end else if (pend_reg || (pin_irq && power_mode == PMRC_CMD_HIB)) begin
			pend_reg <= 1'b1;
			wait_reg <= wait_reg + 16'h0001;
		end
	end
	// ============================================================
	// assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	sequence s_reset_end;
		device_reset ##1 !device_reset;
	endsequence
	sequence s_booted;
		power_mode == PMRC_CMD_ACTIVE && subsys_enable == PMRC_ACT_TMPL_RST;
	endsequence
	a_boot_active: assert property ($past(reset) |-> s_booted)
		else $error("mode not active after boot");
	a_reset_clears: assert property (s_reset_end |-> ##[0:2] s_booted)
		else $error("device reset left state behind");
	a_pin_holds: assert property (!external_reset_pin_n |=> device_reset)
		else $error("device left reset while pin low");
	a_clk_gate: assert property (subsys_clk_en == subsys_enable)
		else $error("clock enable differs from subsystem enable");
	a_hib_hold: assert property (power_mode == PMRC_CMD_HIB |-> io_hold)
		else $error("outputs not held in hibernate");
	a_hib_boost: assert property ((power_mode == PMRC_CMD_HIB) [*2] |-> !boost_standby)
		else $error("boost standby in hibernate");
	a_sleep_off: assert property ((power_mode == PMRC_CMD_SLEEP) [*2] |-> subsys_enable == 8'h00)
		else $error("subsystem enabled in sleep");
	a_hib_resume: assert property (int'(wait_reg) <= HIB_CYCLES + 4)
		else $error("hibernate resume too slow");
	a_pulse_gate: assert property (boost_pulse |-> boost_enable && !$past(boost_pulse))
		else $error("boost pulse without enable or doubled");
endmodule : pmrc_checker

bind pmrc_ctrl pmrc_checker #(.HIB_CYCLES(HIB_CYCLES)) u_pmrc_checker (
	.sys_clk, .reset, .external_reset_pin_n, .pin_irq, .boost_enable, .boost_standby,
	.boost_pulse, .subsys_enable, .subsys_clk_en, .power_mode, .io_hold, .device_reset);

// ===== testbench/pmrc_far.sv
// far side model: reset pin with pull-up, wakeup pins, free running crystal
`timescale 1ns/1ps
module pmrc_far #(
	parameter int XT_HALF = 5
) (
	// clock
	input wire logic sys_clk,
	// bench commands
	input wire logic rst_pin_req,
	input wire logic pin_req,
	input wire logic [7:0] wake_req,
	// pins toward the device
	output logic external_reset_pin_n,
	output logic pin_irq,
	output logic [7:0] wake_irq,
	output logic xtal_32k = 1'b0
);
	int cnt = 0;
	always @(posedge sys_clk) begin
		cnt <= (cnt == XT_HALF - 1) ? 0 : cnt + 1;
		if (cnt == XT_HALF - 1) xtal_32k <= !xtal_32k;
	end
	// pull-up leaves the pin high unless pulled low
	assign external_reset_pin_n = !rst_pin_req;
	assign pin_irq = pin_req;
	assign wake_irq = wake_req;
endmodule : pmrc_far

// ===== testbench/tb.sv
// self-checking bench for the power mode and reset controller
`timescale 1ns/1ps
module tb
	import pmrc_pkg::*;
;
	localparam int SLP = 8;
	localparam int HIB = 10;
	logic sys_clk = 1'b0, reset = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv, v;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, io_hold, supply_irq, timewheel_irq, device_reset;
	logic [1:0] s_axi_bresp, s_axi_rresp, boost_freq_sel, power_mode, rr;
	logic precise_low_voltage_reset = 0, supply_out_of_range = 0, supply_near_limit = 0;
	logic boost_below_target = 0, rst_pin_req = 0, pin_req = 0;
	logic external_reset_pin_n, pin_irq, xtal_32k, boost_enable, boost_standby, boost_pulse;
	logic [7:0] wake_req = 8'h00, wake_irq, subsys_enable, subsys_clk_en;
	int error_cnt = 0, total_checks = 0, cyc = 0, n;
	pmrc_ctrl #(.SLEEP_CYCLES(SLP), .HIB_CYCLES(HIB)) u_pmrc_ctrl (
		.sys_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .external_reset_pin_n,
		.precise_low_voltage_reset, .supply_out_of_range, .supply_near_limit, .wake_irq,
		.pin_irq, .boost_below_target, .xtal_32k, .boost_enable, .boost_standby,
		.boost_freq_sel, .boost_pulse, .subsys_enable, .subsys_clk_en, .power_mode,
		.io_hold, .supply_irq, .timewheel_irq, .device_reset);
	pmrc_far u_pmrc_far (.sys_clk, .rst_pin_req, .pin_req, .wake_req,
		.external_reset_pin_n, .pin_irq, .wake_irq, .xtal_32k);
	always #2 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			finish_test();
		end
	end
	// ============================================================
	// helpers
	function automatic logic [7:0] exp_sub(input logic [1:0] m, input logic [7:0] act, alt);
		case (m)
			PMRC_CMD_ALT: return alt;
			PMRC_CMD_SLEEP, PMRC_CMD_HIB: return 8'h00;
			default: return act;
		endcase
	endfunction : exp_sub
	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk);
	endtask : tick
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		rr = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge sys_clk);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge sys_clk);
	endtask : rd
	task automatic wake_time();
		n = 0;
		pin_req <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (subsys_enable === 8'h00 && n < 200);
		pin_req <= 1'b0;
	endtask : wake_time
	// ============================================================
	// scenarios
	initial begin
		n = $urandom(14);
		tick(2);
		reset <= 1'b0;
		tick(2);
		chk(power_mode, PMRC_CMD_ACTIVE);
		repeat (4) begin
			v = $urandom;
			wr(PMRC_ACT_TMPL_OFS, v);
			wr(PMRC_ALT_TMPL_OFS, ~v);
			tick(2);
			chk(subsys_enable, exp_sub(PMRC_CMD_ACTIVE, v[7:0], ~v[7:0]));
			chk(subsys_clk_en, exp_sub(PMRC_CMD_ACTIVE, v[7:0], ~v[7:0]));
			wr(PMRC_MODE_OFS, PMRC_CMD_ALT);
			tick(2);
			chk(subsys_enable, exp_sub(PMRC_CMD_ALT, v[7:0], ~v[7:0]));
			wr(PMRC_MODE_OFS, PMRC_CMD_ACTIVE);
		end
		wr(PMRC_ACT_TMPL_OFS, 32'h0000_00f1);
		wr(PMRC_WAKE_EN_OFS, 32'h0000_0002);
		wr(PMRC_STATUS_OFS, 32'h0000_0008);
		tick(2);
		chk(subsys_enable, 8'hf0);
		wake_req <= 8'h01;
		tick(3);
		chk(subsys_enable, 8'hf0);
		wake_req <= 8'h02;
		tick(3);
		chk(subsys_enable, 8'hf1);
		wake_req <= 8'h00;
		wr(PMRC_MODE_OFS, PMRC_CMD_ALT);
		wake_req <= 8'h02;
		tick(3);
		chk(power_mode, PMRC_CMD_ACTIVE);
		wake_req <= 8'h00;
		wr(PMRC_MODE_OFS, PMRC_CMD_SLEEP);
		tick(3);
		chk(subsys_enable, exp_sub(PMRC_CMD_SLEEP, 8'hf1, 8'h00));
		wake_time();
		chk(n >= SLP && n <= SLP + 4, 1);
		wr(PMRC_BOOST_OFS, 32'h0000_0003);
		tick(2);
		chk(boost_standby, 1);
		wr(PMRC_MODE_OFS, PMRC_CMD_HIB);
		wake_req <= 8'h02;
		tick(4);
		chk(power_mode, PMRC_CMD_HIB);
		chk(io_hold, 1);
		chk(boost_standby, 0);
		wake_req <= 8'h00;
		wake_time();
		chk(n <= HIB + 4, 1);
		chk(subsys_enable, 8'hf1);
		for (int f = 0; f < 4; f++) begin
			wr(PMRC_BOOST_OFS, 32'h5 | (f << 4));
			boost_below_target <= f[0];
			tick(2);
			n = 0;
			repeat (40) begin
				@(posedge sys_clk);
				n += boost_pulse;
			end
			chk(boost_freq_sel, f[1:0]);
			chk(boost_enable, 1);
			chk(n, f[0] ? 8 : 0);
		end
		wake_req <= 8'h02;
		wr(PMRC_MODE_OFS, PMRC_CMD_SLEEP);
		tick(3);
		chk(subsys_enable, 8'hf1);
		wake_req <= 8'h00;
		wr(PMRC_MODE_OFS, PMRC_CMD_SLEEP);
		rst_pin_req <= 1'b1;
		tick(4);
		chk(device_reset, 1);
		rst_pin_req <= 1'b0;
		tick(4);
		chk(power_mode, PMRC_CMD_ACTIVE);
		chk(subsys_enable, PMRC_ACT_TMPL_RST);
		rd(PMRC_RST_STAT_OFS);
		chk(rv[PMRC_RS_EXTERNAL_RESET_PIN], 1);
		wr(PMRC_SRES_OFS, 32'h0000_0001);
		tick(4);
		rd(PMRC_RST_STAT_OFS);
		chk(rv[PMRC_RS_SRES], 1);
		chk(rv[PMRC_RS_EXTERNAL_RESET_PIN], 0);
		wr(PMRC_CTW_OFS, 32'h0000_0020);
		supply_near_limit <= 1'b1;
		tick(80);
		supply_near_limit <= 1'b0;
		chk(supply_irq, 1);
		chk(timewheel_irq, 1);
		rd(PMRC_RST_STAT_OFS);
		chk(rv[PMRC_RS_SVM_IRQ], 1);
		precise_low_voltage_reset <= 1'b1;
		tick(2);
		chk(device_reset, 1);
		precise_low_voltage_reset <= 1'b0;
		tick(2);
		rd(PMRC_RST_STAT_OFS);
		chk(rv[PMRC_RS_PRECISE_LOW_VOLTAGE_RESET], 1);
		wr(8'h3c, 32'h1);
		chk(rr, PMRC_AXI_SLVERR);
		rd(8'h3c);
		chk(rr, PMRC_AXI_SLVERR);
		chk(rv, 32'h0);
		finish_test();
	end
endmodule : tb
